/* hdl/ppto_defs.vh */
// Constants for the programmable pulse and time-code output block.
`ifndef PPTO_DEFS_VH
`define PPTO_DEFS_VH
`define PPTO_ADDR_CTRL      4'h0
`define PPTO_ADDR_TRIG_DAY  4'h1
`define PPTO_ADDR_TRIG_TIME 4'h2
`define PPTO_ADDR_TRIG_FRAC 4'h3
`define PPTO_ADDR_ROUTE     4'h4
`define PPTO_ADDR_TCBITS    4'h5
`define PPTO_ADDR_STATUS    4'h6
`define PPTO_CTRL_MODE_LSB  0
`define PPTO_CTRL_POL_BIT   2
`define PPTO_CTRL_LOCAL_BIT 3
`define PPTO_CTRL_ARM_BIT   4
`define PPTO_CTRL_RESET     32'h00000000
`define PPTO_MODE_TRIG      2'h0
`define PPTO_MODE_SLOW      2'h1
`define PPTO_MODE_LW        2'h2
`define PPTO_MODE_LW_VAR    2'h3
`define PPTO_SLOW_MIN_S     2
`define PPTO_SLOW_HOUR_S    4
`define PPTO_SLOW_DAY_S     6
`define PPTO_LW_ZERO_MS     100
`define PPTO_LW_ONE_MS      200
`define PPTO_LW_B59_MS      500
`define PPTO_MS_PER_S       1000
`define PPTO_CLK_HZ         100000000
`define PPTO_CYC_PER_MS     (`PPTO_CLK_HZ / `PPTO_MS_PER_S)
`endif

/* hdl/ppto_sync2.v */
// Two-flip-flop synchroniser for level inputs.
`timescale 1ns/1ps
module ppto_sync2 #(
  parameter W = 1
) (
  input  wire         i_clock,
  input  wire         i_arst_n,
  input  wire         i_ce,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else if (i_ce) begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end
  assign o_sync = sync_ff;
endmodule

/* hdl/ppto_top.v */
// Programmable pulse output: yearly one-shot, slow marker code, longwave minute code.
//
// Functional notes
// - The one-shot fires once per year at the set day-of-year, hour, minute, second, fraction.
// - Configuration picks the one-shot idle level, high or low.
// - On firing the output goes to the opposite level and holds until the one-shot is re-armed.
// - In slow code the output is high except during marker lows.
// - Slow code goes low 2 s at each minute, 4 s at each hour, 6 s at each day boundary.
// - The longwave code repeats every minute, aligned to the disciplined time base.
// - The longwave code can be routed to any digital output.
// - The variant sends a 0.5 s pulse in second 59; the standard variant sends none there.
// - The trigger time is compared against UTC or local time as configured.
// - Pulses drive only outputs whose jumper selects the programmable pulse function.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ppto_defs.vh"
module ppto_top #(
  parameter N_OUT       = 3,
  parameter CYC_PER_MS  = `PPTO_CYC_PER_MS
) (
  input  wire             i_clock,
  input  wire             i_arst_n,
  input  wire             i_ce,
  input  wire [3:0]       i_addr,
  input  wire [31:0]      i_wdata,
  input  wire             i_wr,
  input  wire             i_rd,
  output reg  [31:0]      o_rdata,
  input  wire             i_pps,
  input  wire             i_ms_tick,
  input  wire [8:0]       i_utc_day,
  input  wire [4:0]       i_utc_hour,
  input  wire [5:0]       i_utc_min,
  input  wire [5:0]       i_utc_sec,
  input  wire [8:0]       i_loc_day,
  input  wire [4:0]       i_loc_hour,
  input  wire [5:0]       i_loc_min,
  input  wire [5:0]       i_loc_sec,
  input  wire [9:0]       i_msec,
  input  wire [N_OUT-1:0] i_jumper_pp,
  output reg  [N_OUT-1:0] o_pulse_out,
  output wire [N_OUT-1:0] o_pulse_oe
);
  // Time base arrives from the same clock domain; jumpers are pins and are synchronised.
  wire [N_OUT-1:0] jumper_s;
  ppto_sync2 #(.W(N_OUT)) u_jsync (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_ce     (i_ce),
    .i_async  (i_jumper_pp),
    .o_sync   (jumper_s)
  );

  reg [31:0]      ctrl_ff;
  reg [8:0]       trig_day_ff;
  reg [16:0]      trig_time_ff;
  reg [9:0]       trig_ms_ff;
  reg [N_OUT-1:0] route_ff;
  reg [59:0]      tc_bits_ff;
  reg [59:0]      tc_cur_ff;
  reg             fired_ff;
  reg             fired_seen_ff;
  reg [2:0]       slow_left_ff;
  reg             pps_d_ff;
  reg             wave_ff;

  wire [1:0] mode  = ctrl_ff[`PPTO_CTRL_MODE_LSB+1:`PPTO_CTRL_MODE_LSB];
  wire       pol   = ctrl_ff[`PPTO_CTRL_POL_BIT];
  wire       use_l = ctrl_ff[`PPTO_CTRL_LOCAL_BIT];
  wire       arm_w = i_wr && (i_addr == `PPTO_ADDR_CTRL) && i_wdata[`PPTO_CTRL_ARM_BIT];

  // Time reference for the trigger comparison.
  wire [8:0] t_day  = use_l ? i_loc_day  : i_utc_day;
  wire [4:0] t_hour = use_l ? i_loc_hour : i_utc_hour;
  wire [5:0] t_min  = use_l ? i_loc_min  : i_utc_min;
  wire [5:0] t_sec  = use_l ? i_loc_sec  : i_utc_sec;
  wire [16:0] t_sod = {t_hour, t_min, t_sec};
  wire trig_hit = i_ms_tick && (t_day == trig_day_ff) && (t_sod == trig_time_ff)
                  && (i_msec == trig_ms_ff);

  localparam [2:0] SLOW_DAY_S  = `PPTO_SLOW_DAY_S;
  localparam [2:0] SLOW_HOUR_S = `PPTO_SLOW_HOUR_S;
  localparam [2:0] SLOW_MIN_S  = `PPTO_SLOW_MIN_S;
  localparam [9:0] LW_ZERO_MS  = `PPTO_LW_ZERO_MS;
  localparam [9:0] LW_ONE_MS   = `PPTO_LW_ONE_MS;
  localparam [9:0] LW_B59_MS   = `PPTO_LW_B59_MS;

  wire pps_rise = i_pps && !pps_d_ff;
  wire min_b  = pps_rise && (i_utc_sec == 6'h00);
  wire hour_b = min_b && (i_utc_min == 6'h00);
  wire day_b  = hour_b && (i_utc_hour == 5'h00);

  // Register writes and the one-shot latch.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_ff      <= `PPTO_CTRL_RESET;
      trig_day_ff  <= 9'h001;
      trig_time_ff <= 17'h00000;
      trig_ms_ff   <= 10'h000;
      route_ff     <= {N_OUT{1'b0}};
      tc_bits_ff   <= 60'h000000000000000;
      fired_ff     <= 1'b0;
      fired_seen_ff <= 1'b0;
    end else if (i_ce) begin
      if (i_wr) begin
        case (i_addr)
          `PPTO_ADDR_CTRL:      ctrl_ff <= {27'h0000000, 1'b0, i_wdata[3:0]};
          `PPTO_ADDR_TRIG_DAY:  trig_day_ff <= i_wdata[8:0];
          `PPTO_ADDR_TRIG_TIME: trig_time_ff <= i_wdata[16:0];
          `PPTO_ADDR_TRIG_FRAC: trig_ms_ff <= i_wdata[9:0];
          `PPTO_ADDR_ROUTE:     route_ff <= i_wdata[N_OUT-1:0];
          `PPTO_ADDR_TCBITS:    tc_bits_ff <= {i_wdata[27:0], 32'h00000000};
          default: ;
        endcase
      end
      if (mode == `PPTO_MODE_TRIG && trig_hit) begin
        fired_ff      <= 1'b1;
        fired_seen_ff <= 1'b1;
      end else if (arm_w) begin
        fired_ff <= 1'b0;
      end
    end
  end

  // Slow code low time, in whole seconds, with the longest boundary winning.
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slow_left_ff <= 3'h0;
      // Starting high means a pulse already high at release is not taken as a boundary.
      pps_d_ff     <= 1'b1;
    end else if (i_ce) begin
      pps_d_ff <= i_pps;
      if (day_b) begin
        slow_left_ff <= SLOW_DAY_S;
      end else if (hour_b) begin
        slow_left_ff <= SLOW_HOUR_S;
      end else if (min_b) begin
        slow_left_ff <= SLOW_MIN_S;
      end else if (pps_rise && slow_left_ff != 3'h0) begin
        slow_left_ff <= slow_left_ff - 3'h1;
      end
    end
  end

  // Longwave frame: bits latched at second 0, pulse width chosen per second.
  reg [9:0] lw_width;
  always @* begin
    lw_width = tc_cur_ff[i_utc_sec] ? LW_ONE_MS : LW_ZERO_MS;
    if (i_utc_sec == 6'd59) begin
      lw_width = (mode == `PPTO_MODE_LW_VAR) ? LW_B59_MS : 10'h000;
    end
  end
  wire lw_low = (i_msec < lw_width);

  reg wave_nxt;
  always @* begin
    case (mode)
      `PPTO_MODE_TRIG: wave_nxt = fired_ff ? ~pol : pol;
      `PPTO_MODE_SLOW: wave_nxt = (slow_left_ff == 3'h0);
      `PPTO_MODE_LW:   wave_nxt = ~lw_low;
      `PPTO_MODE_LW_VAR: wave_nxt = ~lw_low;
      default: wave_nxt = 1'b1;
    endcase
  end

  // Each output carries the shared waveform only where both jumper and route allow it.
  genvar g;
  generate
    for (g = 0; g < N_OUT; g = g + 1) begin : g_out
      always @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_pulse_out[g] <= 1'b0;
        end else if (i_ce) begin
          o_pulse_out[g] <= jumper_s[g] & route_ff[g] & wave_ff;
        end
      end
    end
  endgenerate

  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tc_cur_ff   <= 60'h000000000000000;
      wave_ff     <= 1'b1;
      o_rdata     <= 32'h00000000;
    end else if (i_ce) begin
      if (min_b) begin
        tc_cur_ff <= tc_bits_ff;
      end
      wave_ff <= wave_nxt;
      o_rdata <= 32'h00000000;
      if (i_rd) begin
        case (i_addr)
          `PPTO_ADDR_CTRL:      o_rdata <= ctrl_ff;
          `PPTO_ADDR_TRIG_DAY:  o_rdata <= {23'h000000, trig_day_ff};
          `PPTO_ADDR_TRIG_TIME: o_rdata <= {15'h0000, trig_time_ff};
          `PPTO_ADDR_TRIG_FRAC: o_rdata <= {22'h000000, trig_ms_ff};
          `PPTO_ADDR_ROUTE:     o_rdata <= {{(32-N_OUT){1'b0}}, route_ff};
          `PPTO_ADDR_TCBITS:    o_rdata <= {4'h0, tc_bits_ff[59:32]};
          `PPTO_ADDR_STATUS:    o_rdata <= {26'h0000000, fired_seen_ff, fired_ff,
                                             wave_ff, slow_left_ff};
          default:              o_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign o_pulse_oe = jumper_s & route_ff;
endmodule

/* verif/ppto_chk.sv */
// Port checker for the programmable pulse output block.
`timescale 1ns/1ps
module ppto_chk #(parameter N_OUT = 3) (
  input wire             i_clock,
  input wire             i_arst_n,
  input wire [3:0]       i_addr,
  input wire             i_wr,
  input wire             i_rd,
  input wire [31:0]      o_rdata,
  input wire [N_OUT-1:0] i_jumper_pp,
  input wire [N_OUT-1:0] o_pulse_out,
  input wire [N_OUT-1:0] o_pulse_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  out_gate_a: assert property ((o_pulse_out & ~o_pulse_oe) == 0)
    else $error("pulse high on undriven output");
  jumper_off_a: assert property ((i_jumper_pp == 0) [*3] |-> o_pulse_oe == 0)
    else $error("output driven without jumper");
  oe_steady_a: assert property ((!i_wr && $stable(i_jumper_pp)) [*4] |-> $stable(o_pulse_oe))
    else $error("output enable moved without cause");
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 0)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) > 4'h6 |-> o_rdata == 0)
    else $error("unmapped read not zero");
  arm_unstored_a: assert property ($past(i_rd) && $past(i_addr) == 4'h0 |-> o_rdata[31:4] == 0)
    else $error("control read shows rearm bit");
  route_width_a: assert property ($past(i_rd) && $past(i_addr) == 4'h4 |-> o_rdata[31:N_OUT] == 0)
    else $error("route read too wide");
  status_width_a: assert property ($past(i_rd) && $past(i_addr) == 4'h6 |-> o_rdata[31:6] == 0)
    else $error("status read too wide");
  cover property ($fell(o_pulse_out[0]));
  cover property ($rose(o_pulse_oe[0]));
  cover property ($past(i_rd) && o_rdata != 0);
endmodule
bind ppto_top ppto_chk #(.N_OUT(N_OUT)) i_chk (.i_clock, .i_arst_n, .i_addr, .i_wr, .i_rd,
  .o_rdata, .i_jumper_pp, .o_pulse_out, .o_pulse_oe);

/* verif/ppto_rx_model.sv */
// Timing receiver on one output pin: measures each low pulse in clock cycles.
`timescale 1ns/1ps
module ppto_rx_model (
  input  wire        i_clock,
  input  wire        i_out,
  input  wire        i_oe,
  output reg  [15:0] o_low_cyc,
  output reg  [7:0]  o_pulses
);
  reg [15:0] run_ff;
  reg        last_ff;
  // The receiver input has a pull-up, so an undriven pin reads high.
  wire       line = i_oe ? i_out : 1'b1;
  initial begin
    run_ff = 16'h0;
    last_ff = 1'b1;
    o_low_cyc = 16'h0;
    o_pulses = 8'h0;
  end
  always @(posedge i_clock) begin
    last_ff <= line;
    run_ff <= line ? 16'h0 : run_ff + 16'h1;
    if (line && !last_ff) begin
      o_low_cyc <= run_ff;
      o_pulses <= o_pulses + 8'h1;
    end
  end
endmodule

/* verif/prog_pulse_time_code_output_tb_top.sv */
// Testbench for the programmable pulse output block.
`timescale 1ns/1ps
module prog_pulse_time_code_output_tb_top;
  logic i_clock, i_arst_n, i_wr, i_rd, ms;
  logic [3:0] i_addr;
  logic [31:0] i_wdata;
  logic [9:0] msec;
  logic [8:0] day;
  logic [4:0] hr;
  logic [5:0] mn, sc;
  logic [2:0] jmp;
  logic [7:0] p;
  wire [31:0] rd;
  wire [2:0] po, poe;
  wire [15:0] low;
  wire [7:0] np;
  int errors, checked, k;
  logic [3:0] ta[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hF};
  logic [31:0] tw[5] = '{32'h1F, 32'h16D, 32'h17EFB, 32'hFF, 32'hFFFFFFFF};
  logic [31:0] te[5] = '{32'hF, 32'h16D, 32'h17EFB, 32'h7, 32'h0};
  ppto_top i_dut (.i_clock, .i_arst_n, .i_ce(1'b1), .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata(rd), .i_pps(msec < 10'h1F4), .i_ms_tick(ms), .i_utc_day(day), .i_utc_hour(hr),
    .i_utc_min(mn), .i_utc_sec(sc), .i_loc_day(day), .i_loc_hour(hr ^ 5'h1), .i_loc_min(mn),
    .i_loc_sec(sc), .i_msec(msec), .i_jumper_pp(jmp), .o_pulse_out(po), .o_pulse_oe(poe));
  ppto_rx_model i_rx (.i_clock, .i_out(po[0]), .i_oe(poe[0]), .o_low_cyc(low), .o_pulses(np));
  always #5 i_clock = ~i_clock;
  // Time base: one millisecond tick every second clock.
  always @(posedge i_clock) begin
    ms <= ~ms;
    if (ms) begin
      msec <= (msec == 10'h3E7) ? 10'h0 : msec + 10'h1;
      if (msec == 10'h3E7) begin
        sc <= (sc == 6'h3B) ? 6'h0 : sc + 6'h1;
        if (sc == 6'h3B) begin
          mn <= (mn == 6'h3B) ? 6'h0 : mn + 6'h1;
          if (mn == 6'h3B) begin
            hr <= (hr == 5'h17) ? 5'h0 : hr + 5'h1;
            if (hr == 5'h17) day <= day + 9'h1;
          end
        end
      end
    end
  end
  task automatic chk(input string n, input [31:0] s, input [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input [3:0] a, input [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input [3:0] a, input [31:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    chk("rdata", rd, e);
  endtask
  // Presets the time at 600 ms on an edge without a tick.
  task automatic set_t(input [4:0] h, input [5:0] m, input [5:0] s);
    @(posedge i_clock);
    if (ms) @(posedge i_clock);
    {hr, mn, sc, msec} <= {h, m, s, 10'h258};
    // Lets an edge caused by the jump reach the receiver before a pulse is awaited.
    repeat (4) @(posedge i_clock);
  endtask
  task automatic pulse(input [31:0] e);
    int n;
    n = 0;
    p = np;
    while (np == p && n < 20000) begin
      @(posedge i_clock);
      n++;
    end
    if (n == 20000) errors++;
    if (n == 20000) test_done;
    chk("low", 32'(low), e);
  endtask
  initial begin
    {i_clock, i_arst_n, i_wr, i_rd, ms, i_addr, i_wdata, msec, hr, mn, sc} = 0;
    day = 9'h7;
    jmp = 3'h1;
    repeat (3) @(posedge i_clock);
    chk("oe_rst", 32'(poe), 0);
    i_arst_n <= 1'b1;
    for (k = 0; k < 5; k++) begin
      wr(ta[k], tw[k]);
      rdc(ta[k], te[k]);
    end
    chk("oe", 32'(poe), 1);
    $display("registers done");
    wr(4'h0, 32'h1);
    set_t(5'h17, 6'h3B, 6'h3A);
    pulse(12000);
    set_t(5'h0, 6'h3B, 6'h3A);
    pulse(8000);
    set_t(5'h0, 6'h0, 6'h3A);
    pulse(4000);
    $display("slow code done");
    wr(4'h5, 32'h4000000);
    for (k = 2; k < 4; k++) begin
      wr(4'h0, k);
      set_t(5'h0, 6'h0, 6'h3A);
      p = np;
      repeat (2000) @(posedge i_clock);
      chk("n59", 32'(np - p), k - 2);
      if (k == 3) chk("w59", 32'(low), 1000);
      pulse(200);
      set_t(5'h0, 6'h1, 6'h39);
      pulse(400);
    end
    $display("longwave done");
    wr(4'h1, 32'h8);
    wr(4'h2, 32'h3105);
    wr(4'h3, 32'hFA);
    wr(4'h0, 32'h1C);
    set_t(5'h2, 6'h4, 6'h4);
    repeat (1200) @(posedge i_clock);
    chk("idle", 32'(po[0]), 1);
    repeat (200) @(posedge i_clock);
    chk("fired", 32'(po[0]), 0);
    repeat (2000) @(posedge i_clock);
    chk("held", 32'(po[0]), 0);
    wr(4'h0, 32'h18);
    repeat (4) @(posedge i_clock);
    chk("idle_lo", 32'(po[0]), 0);
    $display("one-shot done");
    jmp <= 3'h0;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    chk("oe_off", 32'(poe), 0);
    chk("out_off", 32'(po), 0);
    $display("jumper done");
    test_done;
  end
endmodule
